// file: rtl/eair_pkg.sv
// shared constants, encodings and carrier types of the egress action index resolver
package eair_pkg;

  // field widths
  localparam int ENC_W      = 7;
  localparam int SVC_W      = 10;
  localparam int OFS_W      = 24;
  localparam int MIDX_W     = 8;
  localparam int KEY_W      = 4;
  localparam int POP_W      = 5;
  localparam int HPOP_W     = 5;
  localparam int MAP_ADDR_W = 11;
  localparam int POPB_W     = 6;
  localparam int NUM_MAP    = 4;
  localparam int CNT_W      = 16;

  // register byte offsets
  localparam logic [11:0] OFF_ENCAP  = 12'h000;
  localparam logic [11:0] OFF_POP    = 12'h004;
  localparam logic [11:0] OFF_SVC    = 12'h008;
  localparam logic [11:0] OFF_CLSOFS = 12'h00c;
  localparam logic [11:0] OFF_MAPIDX = 12'h010;
  localparam logic [11:0] OFF_MAPKEY = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;

  // register select codes
  localparam logic [2:0] SEL_ENCAP  = 3'h0;
  localparam logic [2:0] SEL_POP    = 3'h1;
  localparam logic [2:0] SEL_SVC    = 3'h2;
  localparam logic [2:0] SEL_CLSOFS = 3'h3;
  localparam logic [2:0] SEL_MAPIDX = 3'h4;
  localparam logic [2:0] SEL_MAPKEY = 3'h5;
  localparam logic [2:0] SEL_STATUS = 3'h6;
  localparam logic [2:0] SEL_NONE   = 3'h7;

  // field positions
  localparam int ENCAP_LSB   = 0;
  localparam int ENCAP_P_LSB = 8;
  localparam int PROT_LSB    = 16;
  localparam int SVC_LSB     = 0;
  localparam int SVC_P_LSB   = 16;

  // values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  RST_PROT = 2'h0;

  // pop override encodings
  localparam logic [4:0] POP_USE_HDR = 5'h00;
  localparam logic [4:0] POP_NONE    = 5'h01;
  localparam logic [4:0] POP_MAX     = 5'h15;

  // protection selection
  localparam logic [1:0] PROT_OFF      = 2'h0;
  localparam logic [1:0] PROT_ACTIVE   = 2'h1;
  localparam logic [1:0] PROT_INACTIVE = 2'h2;

  // mapping key selector codes
  localparam logic [3:0] KEY_QOS      = 4'h0;
  localparam logic [3:0] KEY_DP_QOS   = 4'h1;
  localparam logic [3:0] KEY_DSCP     = 4'h2;
  localparam logic [3:0] KEY_DP_DSCP  = 4'h3;
  localparam logic [3:0] KEY_DP_TOS   = 4'h4;
  localparam logic [3:0] KEY_PCP      = 4'h5;
  localparam logic [3:0] KEY_DP_PCP   = 4'h6;
  localparam logic [3:0] KEY_DEI_PCP  = 4'h7;
  localparam logic [3:0] KEY_TC       = 4'h8;
  localparam logic [3:0] KEY_DP_TC    = 4'h9;
  localparam logic [3:0] KEY_POP_PCP  = 4'ha;
  localparam logic [3:0] KEY_DP_PPCP  = 4'hb;
  localparam logic [3:0] KEY_PDEI_PCP = 4'hc;
  localparam logic [3:0] KEY_COS      = 4'hd;
  localparam logic [3:0] KEY_DP_COS   = 4'he;

  // internal frame header fields seen by the resolver
  typedef struct packed {
    logic [HPOP_W-1:0] header_word_pop_count;
    logic              prot_active;
    logic [2:0]        qos;
    logic [1:0]        dp;
    logic [5:0]        dscp;
    logic [2:0]        tos_precedence;
    logic [2:0]        pcp;
    logic              dei;
    logic [2:0]        tc;
    logic [2:0]        pop_pcp;
    logic              pop_dei;
    logic [2:0]        class_of_service_id;
  } eair_hdr_t;

  // resolved action
  typedef struct packed {
    logic                             encap_push;
    logic [ENC_W-1:0]                 encap_table_index;
    logic [POPB_W-1:0]                pop_bytes;
    logic                             pop_invalid;
    logic                             prot_used;
    logic [SVC_W-1:0]                 counter_index;
    logic [1:0][MAP_ADDR_W-1:0]       res_a_index;
    logic [1:0][MAP_ADDR_W-1:0]       res_b_index;
    logic [NUM_MAP-1:0]               map_valid;
  } eair_res_t;

endpackage

// file: rtl/eair_map_key.sv
// key selection and address build for one mapping table
`timescale 1ns/1ps
module eair_map_key (
  input  wire logic [eair_pkg::KEY_W-1:0]      key,
  input  wire logic [eair_pkg::MIDX_W-1:0]     map_base_index,
  input  wire eair_pkg::eair_hdr_t             hdr,
  output logic      [eair_pkg::MAP_ADDR_W-1:0] index,
  output logic                                 valid
);

  logic [7:0]                      off;
  logic [eair_pkg::MAP_ADDR_W-1:0] base_shift;

  // group value times eight plus a 3-bit value
  function automatic logic [7:0] grp8(input logic [1:0] g, input logic [2:0] v);
    return {3'b000, g, v};
  endfunction

  // offset chosen by the key; unused code leaves the bare base and flags it
  always_comb begin
    off   = 8'h00;
    valid = 1'b1;
    case (key)
      eair_pkg::KEY_QOS:      off = {5'h00, hdr.qos};
      eair_pkg::KEY_DP_QOS:   off = grp8(hdr.dp, hdr.qos);
      eair_pkg::KEY_DSCP:     off = {2'b00, hdr.dscp};
      eair_pkg::KEY_DP_DSCP:  off = {hdr.dp, hdr.dscp};
      eair_pkg::KEY_DP_TOS:   off = grp8(hdr.dp, hdr.tos_precedence);
      eair_pkg::KEY_PCP:      off = {5'h00, hdr.pcp};
      eair_pkg::KEY_DP_PCP:   off = grp8(hdr.dp, hdr.pcp);
      eair_pkg::KEY_DEI_PCP:  off = grp8({1'b0, hdr.dei}, hdr.pcp);
      eair_pkg::KEY_TC:       off = {5'h00, hdr.tc};
      eair_pkg::KEY_DP_TC:    off = grp8(hdr.dp, hdr.tc);
      eair_pkg::KEY_POP_PCP:  off = {5'h00, hdr.pop_pcp};
      eair_pkg::KEY_DP_PPCP:  off = grp8(hdr.dp, hdr.pop_pcp);
      eair_pkg::KEY_PDEI_PCP: off = grp8({1'b0, hdr.pop_dei}, hdr.pop_pcp);
      eair_pkg::KEY_COS:      off = {5'h00, hdr.class_of_service_id};
      eair_pkg::KEY_DP_COS:   off = grp8(hdr.dp, hdr.class_of_service_id);
      default:                valid = 1'b0;
    endcase
  end

  assign index = eair_pkg::MAP_ADDR_W'({base_shift} + {3'b000, off});

  // base shifted into the upper eight address bits
  assign base_shift = {map_base_index, 3'b000};

endmodule // eair_map_key

// file: rtl/eair_resolver.sv
// egress action index resolver: apb action registers, resolution logic and result register
`timescale 1ns/1ps
//
// Contract
// - zero encap index disables push
// - protect encap index used when selected
// - nonzero pop override up to 0x15 replaces header count
// - override one pops none, n pops 2n
// - override larger than header uses header
// - service base addresses counter set
// - protect service base used when selected
// - counter index adds per-class 3-bit offset
// - map base gives address bits 10:3
// - tables 0,1 resource A; 2,3 B
// - four tables share one key encoding
// - keys 0,1 qos and dp-qos
// - keys 2,3,4 dscp and tos keys
// - keys 5,6,7 pcp keys
// - keys 8,9 mpls traffic class keys
// - keys 10-12 popped customer tag keys
// - keys 13,14 class-of-service keys
// - protect select 1 active, 2 inactive
module eair_resolver #(
  parameter int ADDR_W = 12
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 frame_valid,
  input  wire eair_pkg::eair_hdr_t  frame_hdr,
  output logic                      result_valid,
  output eair_pkg::eair_res_t       result
);

  // the offsets are compared on 12 bits
  if (ADDR_W < 12) begin : g_bad_addr
    $error("eair_resolver: ADDR_W must be at least 12");
  end

  // action registers
  logic [eair_pkg::ENC_W-1:0]  encap_table_index_q;
  logic [eair_pkg::ENC_W-1:0]  encap_table_index_protect_q;
  logic [1:0]                  prot_sel_q;
  logic [eair_pkg::POP_W-1:0]  pop_override_q;
  logic [eair_pkg::SVC_W-1:0]  service_counter_base_q;
  logic [eair_pkg::SVC_W-1:0]  service_counter_base_protect_q;
  logic [eair_pkg::OFS_W-1:0]  per_class_counter_offset_q;
  logic [eair_pkg::NUM_MAP-1:0][eair_pkg::MIDX_W-1:0] map_base_q;
  logic [eair_pkg::NUM_MAP-1:0][eair_pkg::KEY_W-1:0]  map_key_q;
  logic [eair_pkg::CNT_W-1:0]  frame_cnt_q;

  // bus signals
  logic [2:0]  rsel;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  logic        setup;
  logic        wr_en;

  // register select from byte address; misaligned or unknown is no register
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [11:0] lo;
    lo = a[11:0];
    // a shift keeps this legal when ADDR_W is exactly 12
    if ((a >> 12) != '0) return eair_pkg::SEL_NONE;
    case (lo)
      eair_pkg::OFF_ENCAP:  return eair_pkg::SEL_ENCAP;
      eair_pkg::OFF_POP:    return eair_pkg::SEL_POP;
      eair_pkg::OFF_SVC:    return eair_pkg::SEL_SVC;
      eair_pkg::OFF_CLSOFS: return eair_pkg::SEL_CLSOFS;
      eair_pkg::OFF_MAPIDX: return eair_pkg::SEL_MAPIDX;
      eair_pkg::OFF_MAPKEY: return eair_pkg::SEL_MAPKEY;
      eair_pkg::OFF_STATUS: return eair_pkg::SEL_STATUS;
      default:              return eair_pkg::SEL_NONE;
    endcase
  endfunction

  // byte lane merge of write data over the current word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // current word of the addressed register, reserved bits zero
  always_comb begin
    rsel     = reg_sel(paddr);
    cur_word = eair_pkg::RST_WORD;
    case (rsel)
      eair_pkg::SEL_ENCAP: begin
        cur_word[eair_pkg::ENCAP_LSB +: eair_pkg::ENC_W]   = encap_table_index_q;
        cur_word[eair_pkg::ENCAP_P_LSB +: eair_pkg::ENC_W] = encap_table_index_protect_q;
        cur_word[eair_pkg::PROT_LSB +: 2]                  = prot_sel_q;
      end
      eair_pkg::SEL_POP:    cur_word[eair_pkg::POP_W-1:0] = pop_override_q;
      eair_pkg::SEL_SVC: begin
        cur_word[eair_pkg::SVC_LSB +: eair_pkg::SVC_W]   = service_counter_base_q;
        cur_word[eair_pkg::SVC_P_LSB +: eair_pkg::SVC_W] = service_counter_base_protect_q;
      end
      eair_pkg::SEL_CLSOFS: cur_word[eair_pkg::OFS_W-1:0] = per_class_counter_offset_q;
      eair_pkg::SEL_MAPIDX: cur_word = map_base_q;
      eair_pkg::SEL_MAPKEY: cur_word[15:0] = map_key_q;
      eair_pkg::SEL_STATUS: begin
        cur_word[eair_pkg::CNT_W-1:0] = frame_cnt_q;
        cur_word[19:16]               = result.map_valid;
        cur_word[20]                  = result.encap_push;
        cur_word[21]                  = result.pop_invalid;
        cur_word[22]                  = result.prot_used;
      end
      default:              cur_word = eair_pkg::RST_WORD;
    endcase
    new_word = lane_merge(cur_word, pwdata, pstrb);
  end

  // apb answer: one wait-free access phase, data and error captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= eair_pkg::RST_WORD;
    end else begin
      pready  <= setup;
      pslverr <= setup && (rsel == eair_pkg::SEL_NONE);
      if (setup && !pwrite) begin
        prdata <= cur_word;
      end
    end
  end

  // encap and protection register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encap_table_index_q         <= '0;
      encap_table_index_protect_q <= '0;
      prot_sel_q                  <= eair_pkg::RST_PROT;
    end else if (wr_en && rsel == eair_pkg::SEL_ENCAP) begin
      encap_table_index_q         <= new_word[eair_pkg::ENCAP_LSB +: eair_pkg::ENC_W];
      encap_table_index_protect_q <= new_word[eair_pkg::ENCAP_P_LSB +: eair_pkg::ENC_W];
      prot_sel_q                  <= new_word[eair_pkg::PROT_LSB +: 2];
    end
  end

  // pop override register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_override_q <= eair_pkg::POP_USE_HDR;
    end else if (wr_en && rsel == eair_pkg::SEL_POP) begin
      pop_override_q <= new_word[eair_pkg::POP_W-1:0];
    end
  end

  // service counter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      service_counter_base_q         <= '0;
      service_counter_base_protect_q <= '0;
      per_class_counter_offset_q     <= '0;
    end else if (wr_en && rsel == eair_pkg::SEL_SVC) begin
      service_counter_base_q         <= new_word[eair_pkg::SVC_LSB +: eair_pkg::SVC_W];
      service_counter_base_protect_q <= new_word[eair_pkg::SVC_P_LSB +: eair_pkg::SVC_W];
    end else if (wr_en && rsel == eair_pkg::SEL_CLSOFS) begin
      per_class_counter_offset_q     <= new_word[eair_pkg::OFS_W-1:0];
    end
  end

  // mapping base and key registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_base_q <= '0;
      map_key_q  <= '0;
    end else if (wr_en && rsel == eair_pkg::SEL_MAPIDX) begin
      map_base_q <= new_word;
    end else if (wr_en && rsel == eair_pkg::SEL_MAPKEY) begin
      map_key_q  <= new_word[15:0];
    end
  end

  // resolution, all combinational from config and the presented header
  logic                             use_prot;
  logic [eair_pkg::POPB_W-1:0]      hdr_bytes;
  logic [eair_pkg::POPB_W-1:0]      ovr_bytes;
  logic                             ovr_rsvd;
  logic [eair_pkg::POPB_W-1:0]      pop_sel;
  logic [eair_pkg::SVC_W-1:0]       svc_sel;
  logic [2:0]                       cls_off;
  logic [eair_pkg::ENC_W-1:0]       encap_sel;
  logic [eair_pkg::NUM_MAP-1:0][eair_pkg::MAP_ADDR_W-1:0] map_idx;
  logic [eair_pkg::NUM_MAP-1:0]     map_ok;

  // protection substitution; reserved select acts as off
  assign use_prot = ((prot_sel_q == eair_pkg::PROT_ACTIVE) && frame_hdr.prot_active) ||
                    ((prot_sel_q == eair_pkg::PROT_INACTIVE) && !frame_hdr.prot_active);

  assign encap_sel = use_prot ? encap_table_index_protect_q : encap_table_index_q;

  // override bytes, value one pops none
  assign hdr_bytes = {frame_hdr.header_word_pop_count, 1'b0};
  assign ovr_bytes = (pop_override_q == eair_pkg::POP_NONE) ? '0 : {pop_override_q, 1'b0};
  // reserved override falls back to header
  assign ovr_rsvd  = pop_override_q > eair_pkg::POP_MAX;

  // nonzero override up to POP_MAX wins; never beyond header amount
  always_comb begin
    if (pop_override_q == eair_pkg::POP_USE_HDR || ovr_rsvd || ovr_bytes > hdr_bytes) begin
      pop_sel = hdr_bytes;
    end else begin
      pop_sel = ovr_bytes;
    end
  end

  assign svc_sel = use_prot ? service_counter_base_protect_q : service_counter_base_q;
  assign cls_off = per_class_counter_offset_q[3*int'(frame_hdr.class_of_service_id) +: 3];

  // one key decoder per table, same encoding
  for (genvar m = 0; m < eair_pkg::NUM_MAP; m++) begin : g_map
    eair_map_key u_key (
      .key            (map_key_q[m]),
      .map_base_index (map_base_q[m]),
      .hdr            (frame_hdr),
      .index          (map_idx[m]),
      .valid          (map_ok[m])
    );
  end

  // result register, loaded once per presented frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid <= 1'b0;
      result       <= '0;
    end else begin
      result_valid <= frame_valid;
      if (frame_valid) begin
        result.encap_push        <= encap_sel != '0;
        result.encap_table_index <= encap_sel;
        result.pop_bytes         <= pop_sel;
        result.pop_invalid       <= ovr_rsvd;
        result.prot_used         <= use_prot;
        // counter set index from service base
        result.counter_index     <= eair_pkg::SVC_W'(svc_sel + {7'h00, cls_off});
        // tables 0,1 to resource A, 2,3 to resource B
        result.res_a_index       <= {map_idx[1], map_idx[0]};
        result.res_b_index       <= {map_idx[3], map_idx[2]};
        result.map_valid         <= map_ok;
      end
    end
  end

  // resolved frame count, wraps; visible in the status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_q <= '0;
    end else if (frame_valid) begin
      frame_cnt_q <= frame_cnt_q + 1'b1;
    end
  end

  chk_encap_push: assert property (
    @(posedge pclk) disable iff (!presetn)
    result_valid |-> (result.encap_push == (result.encap_table_index != '0)))
    else $error("encap push does not follow index");

  // protect encap index when protection active
  chk_encap_protect: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && prot_sel_q == eair_pkg::PROT_ACTIVE && frame_hdr.prot_active)
    |=> (result.encap_table_index == $past(encap_table_index_protect_q)))
    else $error("protect encap index not used");

  chk_prot_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && prot_sel_q == eair_pkg::PROT_OFF)
    |=> (!result.prot_used && result.counter_index[eair_pkg::SVC_W-1:0] ==
         eair_pkg::SVC_W'($past(service_counter_base_q) +
                          {7'h00, $past(cls_off)})))
    else $error("substitution with protection off");

  chk_pop_header: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && pop_override_q == eair_pkg::POP_USE_HDR)
    |=> (result.pop_bytes == {$past(frame_hdr.header_word_pop_count), 1'b0}))
    else $error("header pop count not used");

  chk_pop_none: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && pop_override_q == eair_pkg::POP_NONE) |=> (result.pop_bytes == '0))
    else $error("override one popped bytes");

  // never pop more than the header amount
  chk_pop_clamp: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_valid |=> (result.pop_bytes <= {$past(frame_hdr.header_word_pop_count), 1'b0}))
    else $error("pop exceeds header amount");

  // counter index equals base plus class offset
  chk_counter_index: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_valid |=> (result.counter_index == eair_pkg::SVC_W'($past(svc_sel) +
                                                             {7'h00, $past(cls_off)})))
    else $error("counter index wrong");

  // qos key keeps base in bits 10:3
  chk_map_base: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && map_key_q[0] == eair_pkg::KEY_QOS)
    |=> (result.res_a_index[0][10:3] == $past(map_base_q[0]) && result.map_valid[0]))
    else $error("map base bits wrong");

  chk_key_invalid: assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_valid && map_key_q[3] == 4'hf) |=> !result.map_valid[3])
    else $error("unused key not invalid");

  // a result follows each frame by exactly one cycle
  chk_result_timing: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_valid |=> result_valid ##1 (result_valid == $past(frame_valid)))
    else $error("result timing wrong");

endmodule // eair_resolver

// file: dv/eair_rewriter_model.sv
// behavioural frame rewriter: sends one header per request, captures the resolved action
`timescale 1ns/1ps
module eair_rewriter_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                req,
  input  wire eair_pkg::eair_hdr_t hdr_in,
  output logic                     frame_valid,
  output eair_pkg::eair_hdr_t      frame_hdr,
  input  wire logic                result_valid,
  input  wire eair_pkg::eair_res_t result,
  output eair_pkg::eair_res_t      seen,
  output logic                     seen_valid
);
  // header only means something with frame_valid; scramble it otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_valid <= 1'h0;
      frame_hdr   <= '0;
    end else begin
      frame_valid <= req;
      frame_hdr   <= req ? hdr_in : ~frame_hdr;
    end
  end
  // result stands until the next frame, but we keep our own copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen       <= '0;
      seen_valid <= 1'h0;
    end else begin
      seen_valid <= result_valid;
      if (result_valid) seen <= result;
    end
  end
endmodule // eair_rewriter_model

// file: dv/eair_resolver_test.sv
// self-checking bench of the egress action index resolver
`timescale 1ns/1ps
module eair_resolver_test;
  logic                pclk, presetn, psel, penable, pwrite, req, pready, pslverr;
  logic                fv, rv, sv, er, u;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd, kd;
  logic [1:0]          sel;
  logic [6:0]          p;
  logic [10:0]         ei, gi;
  eair_pkg::eair_hdr_t hin, fh, h;
  eair_pkg::eair_res_t res, s;
  int                  n_fail, tests_run;
  // key offsets for the fixed header below, key 0 to 15
  logic [7:0] off [16] = '{8'h05, 8'h15, 8'h2a, 8'haa, 8'h13, 8'h06, 8'h16, 8'h0e,
                           8'h04, 8'h14, 8'h02, 8'h12, 8'h0a, 8'h07, 8'h17, 8'h00};
  logic [4:0] ov [6] = '{5'h00, 5'h01, 5'h02, 5'h0b, 5'h15, 5'h16};
  logic [4:0] hp [6] = '{5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h1f, 5'h0a};
  logic [5:0] pb [6] = '{6'h14, 6'h00, 6'h04, 6'h14, 6'h2a, 6'h14};

  eair_resolver eair_resolver_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_valid(fv),
    .frame_hdr(fh), .result_valid(rv), .result(res));
  eair_rewriter_model eair_rewriter_model_inst (.pclk(pclk), .presetn(presetn),
    .req(req), .hdr_in(hin), .frame_valid(fv), .frame_hdr(fh), .result_valid(rv),
    .result(res), .seen(s), .seen_valid(sv));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      n_fail++;
    end
  endtask

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // pready, prdata and pslverr are read at the rising edge that completes the access
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask

  task automatic frame(input eair_pkg::eair_hdr_t x);
    @(posedge pclk);
    req <= 1'h1; hin <= x;
    @(posedge pclk);
    req <= 1'h0;
    do @(negedge pclk); while (sv !== 1'h1);
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; req = 1'h0;
    paddr = 12'h000; pwdata = 32'h0000_0000; hin = '0;
    h = '{header_word_pop_count:5'h0a, prot_active:1'h1, qos:3'h5, dp:2'h2,
          dscp:6'h2a, tos_precedence:3'h3, pcp:3'h6, dei:1'h1, tc:3'h4,
          pop_pcp:3'h2, pop_dei:1'h1, class_of_service_id:3'h7};
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, eair_pkg::OFF_POP, 32'h0000_0000);
    chk("pop_reset", 32'h0000_0000, rd);
    apb(1'h1, eair_pkg::OFF_POP, 32'hffff_ffff);
    apb(1'h0, eair_pkg::OFF_POP, 32'h0000_0000);
    chk("pop_rdback", 32'h0000_001f, rd);
    apb(1'h0, 12'h020, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, er);
    apb(1'h1, eair_pkg::OFF_SVC, 32'h03f0_01ff);
    apb(1'h1, eair_pkg::OFF_CLSOFS, 32'h00a0_0000);
    apb(1'h1, eair_pkg::OFF_MAPIDX, 32'h8140_02ff);
    // protection select with active and inactive header flag
    for (int i = 0; i < 5; i++) begin
      sel = (i < 4) ? 2'(i) : 2'h2;
      p = (i == 3) ? 7'h7f : 7'h00;
      h.prot_active = (i < 4);
      u = (sel == 2'h1 && h.prot_active) || (sel == 2'h2 && !h.prot_active);
      apb(1'h1, eair_pkg::OFF_ENCAP, {14'h0000, sel, 1'h0, 7'h55, 1'h0, p});
      frame(h);
      chk("encap_idx", u ? 7'h55 : p, s.encap_table_index);
      chk("encap_push", u || p != 7'h00, s.encap_push);
      chk("cnt_idx", u ? 10'h3f5 : 10'h204, s.counter_index);
      chk("prot_used", u, s.prot_used);
    end
    // pop override against header count, clamp and reserved codes
    for (int j = 0; j < 6; j++) begin
      apb(1'h1, eair_pkg::OFF_POP, {27'h000_0000, ov[j]});
      h.header_word_pop_count = hp[j];
      frame(h);
      chk("pop_bytes", pb[j], s.pop_bytes);
      chk("pop_invalid", ov[j] == 5'h16, s.pop_invalid);
    end
    // every key code once, four tables at a time
    for (int i = 0; i < 4; i++) begin
      kd = 32'h0000_0000;
      for (int m = 0; m < 4; m++) kd[4*m+:4] = 4'(4*i+m);
      apb(1'h1, eair_pkg::OFF_MAPKEY, kd);
      frame(h);
      for (int m = 0; m < 4; m++) begin
        ei = {32'h8140_02ff >> (8*m), 3'h0} + {3'h0, off[4*i+m]};
        gi = (m < 2) ? s.res_a_index[m] : s.res_b_index[m-2];
        chk("map_idx", ei, gi);
        chk("map_valid", 4*i+m != 15, s.map_valid[m]);
      end
    end
    // status: 15 frames, last map_valid 0111, push, reserved pop and protection all set
    apb(1'h0, eair_pkg::OFF_STATUS, 32'h0000_0000);
    chk("status", 32'h0077_000f, rd);
    tally_and_finish();
  end
endmodule // eair_resolver_test
